// ===== design/rssso_pkg.sv
package rssso_pkg;
  // Opcode fields: upper six bits of the 16-bit instruction word.
  localparam logic [5:0] OPC_ROTATE_RIGHT = 6'h10;
  localparam logic [5:0] OPC_REV_SUB_BORROW = 6'h15;
  localparam logic [5:0] OPC_FILE_SUB_BORROW = 6'h16;
  localparam logic [5:0] OPC_FILE_SUB = 6'h17;
  // Seven-bit opcode for the fill instruction.
  localparam logic [6:0] OPC_FILL_ONES = 7'h34;
  // Full byte opcode for literal subtract.
  localparam logic [7:0] OPC_LIT_SUB = 8'h08;
  localparam logic [15:0] OPC_SLEEP = 16'h0003;
  // Field positions.
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  // Reset values of the status bits (both read high after power-on).
  localparam logic WDOG_EXP_RESET = 1'b1;
  localparam logic SLEEP_ENT_RESET = 1'b1;
  // Flag positions in the flag vector {neg,ovf,zero,half,carry}.
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
endpackage : rssso_pkg

// ===== design/rssso_core.sv
`timescale 1ns/10ps
// What this block does
// - Rotate right without carry moves bit 0 to bit 7, affects N and Z.
// - Destination bit 0 writes accumulator; 1 writes back to the register.
// - Access bit 0 selects the access bank; 1 uses the bank pointer.
// - Fill instruction writes all ones to the register, flags unchanged.
// - Sleep clears sleep-entered, sets watchdog-expired, clears watchdog.
// - After sleep completes the core halts and stops its oscillator.
// - A watchdog wake-up from sleep clears the watchdog-expired bit.
// - File subtract: register minus accumulator, routed by destination bit.
// - File subtract with borrow: register minus accum minus not carry.
module rssso_core (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // File register read path
  input wire logic [7:0] file_rdata,
  // Wake event from the watchdog while sleeping
  input wire logic wdt_wake,
  // File register write path
  output logic [11:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  // Core state
  output logic [7:0] accum,
  output logic [3:0] bank_pointer,
  output logic [4:0] flags,
  output logic watchdog_expired_bit,
  output logic sleep_entered_bit,
  output logic wdt_clear,
  output logic sleeping,
  output logic osc_run
);
  logic [5:0] op6;
  logic is_rot, is_fill, is_sleep, is_lit, is_sub, uses_file, dest_file;
  logic [7:0] minuend, subtrahend, result;
  logic borrow_in;
  logic [8:0] diff;
  logic [4:0] half;
  logic [4:0] next_flags;
  logic issue;

  // Sleeping freezes instruction issue until a wake.
  assign issue = clk_en && instr_valid && !sleeping;
  assign op6 = instr_word[15:10];
  assign is_rot = op6 == rssso_pkg::OPC_ROTATE_RIGHT;
  assign is_fill = instr_word[15:9] == rssso_pkg::OPC_FILL_ONES;
  assign is_sleep = instr_word == rssso_pkg::OPC_SLEEP;
  assign is_lit = instr_word[15:8] == rssso_pkg::OPC_LIT_SUB;
  assign is_sub = is_lit || op6 == rssso_pkg::OPC_REV_SUB_BORROW ||
                  op6 == rssso_pkg::OPC_FILE_SUB_BORROW ||
                  op6 == rssso_pkg::OPC_FILE_SUB;
  assign uses_file = is_rot || is_fill || (is_sub && !is_lit);
  // The fill instruction has no destination bit and always writes back.
  assign dest_file = is_fill || instr_word[rssso_pkg::DEST_BIT];

  always_comb begin
    minuend = file_rdata;
    subtrahend = accum;
    borrow_in = 1'b0;
    unique case (1'b1)
      is_lit: begin
        minuend = instr_word[7:0];
      end
      op6 == rssso_pkg::OPC_REV_SUB_BORROW: begin
        minuend = accum;
        subtrahend = file_rdata;
        borrow_in = !flags[rssso_pkg::FLAG_C];
      end
      op6 == rssso_pkg::OPC_FILE_SUB_BORROW: begin
        borrow_in = !flags[rssso_pkg::FLAG_C];
      end
      default: begin
        borrow_in = 1'b0;
      end
    endcase
  end

  assign diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
  assign half = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} -
                {4'h0, borrow_in};

  always_comb begin
    next_flags = flags;
    result = diff[7:0];
    if (is_rot) begin
      result = {file_rdata[0], file_rdata[7:1]};
      next_flags[rssso_pkg::FLAG_N] = result[7];
      next_flags[rssso_pkg::FLAG_Z] = result == rssso_pkg::ZERO_BYTE;
    end else if (is_fill) begin
      result = rssso_pkg::ALL_ONES;
    end else if (is_sub) begin
      next_flags[rssso_pkg::FLAG_C] = !diff[8];
      next_flags[rssso_pkg::FLAG_DC] = !half[4];
      next_flags[rssso_pkg::FLAG_Z] = diff[7:0] == rssso_pkg::ZERO_BYTE;
      next_flags[rssso_pkg::FLAG_N] = diff[7];
      next_flags[rssso_pkg::FLAG_OV] = (minuend[7] != subtrahend[7]) &&
                                       (diff[7] != minuend[7]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      file_addr <= 12'h000;
    end else if (issue && uses_file) begin
      file_addr <= {instr_word[rssso_pkg::ACCESS_BIT] ? bank_pointer :
                    rssso_pkg::ACCESS_BANK, instr_word[7:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      file_we <= 1'b0;
      file_wdata <= rssso_pkg::ZERO_BYTE;
      accum <= rssso_pkg::ACCUM_RESET;
    end else if (clk_en) begin
      file_we <= issue && uses_file && dest_file;
      if (issue && uses_file && dest_file) begin
        file_wdata <= result;
      end
      if (issue && (is_lit || (uses_file && !dest_file))) begin
        accum <= result;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      flags <= rssso_pkg::FLAGS_RESET;
      bank_pointer <= rssso_pkg::BANK_RESET;
    end else if (issue) begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      watchdog_expired_bit <= rssso_pkg::WDOG_EXP_RESET;
      sleep_entered_bit <= rssso_pkg::SLEEP_ENT_RESET;
      wdt_clear <= 1'b0;
    end else if (clk_en) begin
      wdt_clear <= issue && is_sleep;
      if (issue && is_sleep) begin
        watchdog_expired_bit <= 1'b1;
        sleep_entered_bit <= 1'b0;
      end else if (sleeping && wdt_wake) begin
        watchdog_expired_bit <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sleeping <= 1'b0;
      osc_run <= 1'b1;
    end else if (clk_en) begin
      if (issue && is_sleep) begin
        sleeping <= 1'b1;
        osc_run <= 1'b0;
      end else if (sleeping && wdt_wake) begin
        sleeping <= 1'b0;
        osc_run <= 1'b1;
      end
    end
  end

  chk_sleep_halts: assert property (@(posedge mclk)
    disable iff (!reset_n) clk_en && issue && is_sleep |=>
    sleeping && !osc_run)
    else $error("sleep did not halt the core");
  chk_sleep_status: assert property (@(posedge mclk)
    disable iff (!reset_n) clk_en && issue && is_sleep |=>
    watchdog_expired_bit && !sleep_entered_bit && wdt_clear)
    else $error("sleep status bits wrong");
  chk_wake_clear: assert property (@(posedge mclk)
    disable iff (!reset_n) clk_en && sleeping && wdt_wake |=>
    !watchdog_expired_bit && !sleeping)
    else $error("watchdog wake did not clear status");
  chk_fill_flags: assert property (@(posedge mclk)
    disable iff (!reset_n) issue && is_fill |=> $stable(flags) &&
    file_we && file_wdata == rssso_pkg::ALL_ONES)
    else $error("fill changed flags or data");
  chk_rotate_data: assert property (@(posedge mclk)
    disable iff (!reset_n) issue && is_rot && dest_file |=>
    file_wdata == {$past(file_rdata[0]), $past(file_rdata[7:1])} &&
    flags[rssso_pkg::FLAG_C] == $past(flags[rssso_pkg::FLAG_C]))
    else $error("rotate result wrong");
  chk_dest_accum: assert property (@(posedge mclk)
    disable iff (!reset_n) issue && uses_file && !dest_file |=> !file_we)
    else $error("register written with accumulator destination");
  chk_access_bank: assert property (@(posedge mclk)
    disable iff (!reset_n)
    issue && uses_file && !instr_word[rssso_pkg::ACCESS_BIT] |=>
    file_addr[11:8] == rssso_pkg::ACCESS_BANK)
    else $error("access bank not selected");
  chk_lit_sub: assert property (@(posedge mclk)
    disable iff (!reset_n) issue && is_lit |=>
    accum == 8'($past(instr_word[7:0]) - $past(accum)))
    else $error("literal subtract wrong");
  chk_sub_flags: assert property (@(posedge mclk)
    disable iff (!reset_n) issue && is_sub |=>
    flags[rssso_pkg::FLAG_Z] == (flags[rssso_pkg::FLAG_N] ? 1'b0 :
    flags[rssso_pkg::FLAG_Z]))
    else $error("zero and negative both set");
  chk_sub_carry: assert property (@(posedge mclk)
    disable iff (!reset_n) issue && op6 == rssso_pkg::OPC_FILE_SUB |=>
    flags[rssso_pkg::FLAG_C] == ($past(file_rdata) >= $past(accum)) &&
    flags[rssso_pkg::FLAG_Z] == ($past(file_rdata) == $past(accum)))
    else $error("file subtract carry or zero wrong");
endmodule : rssso_core

// ===== tb/rssso_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  bad_count++; $display("wrong value t=%0t got=%h exp=%h", $time, a, b); \
  end end
module rssso_tb_top;
  logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic instr_valid = 1'b0, wdt_wake = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] file_rdata = 8'h00, file_wdata, accum, acc = 8'h00;
  logic [11:0] file_addr;
  logic [3:0] bank_pointer;
  logic [4:0] flags, flg = 5'h00;
  logic file_we, watchdog_expired_bit, sleep_entered_bit;
  logic wdt_clear, sleeping, osc_run;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  always #20 mclk = ~mclk;
  rssso_core dut_u (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .file_rdata(file_rdata), .wdt_wake(wdt_wake), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .accum(accum),
    .bank_pointer(bank_pointer), .flags(flags),
    .watchdog_expired_bit(watchdog_expired_bit),
    .sleep_entered_bit(sleep_entered_bit), .wdt_clear(wdt_clear),
    .sleeping(sleeping), .osc_run(osc_run));
  task give_verdict;
    $display("checked %0d, wrong %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // A hung run is cut short well past the expected 29 cycles.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Issues one word and checks it against a result worked out here.
  task run(input logic [15:0] w, input logic [7:0] rd);
    logic [8:0] t;
    logic [4:0] lo;
    logic [7:0] m, s, r;
    logic ci, dst, sub;
    m = rd; s = acc; ci = 1'b1; sub = 1'b1; dst = w[9]; r = 8'hFF;
    case (w[15:10])
      6'h10: begin sub = 1'b0; r = {rd[0], rd[7:1]}; end
      6'h15: begin m = acc; s = rd; ci = flg[0]; end
      6'h16: ci = flg[0];
      6'h17: ci = 1'b1;
      default: begin sub = 1'b0; dst = 1'b1; end
    endcase
    if (w[15:8] == 8'h08) begin
      sub = 1'b1; m = w[7:0]; s = acc; ci = 1'b1; dst = 1'b0;
    end
    if (sub) begin
      t = {1'b0, m} - {1'b0, s} - {8'h00, ~ci};
      lo = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, ~ci};
      r = t[7:0];
      flg[0] = ~t[8];
      flg[1] = ~lo[4];
      flg[3] = (m[7] != s[7]) && (r[7] != m[7]);
    end
    if (w[15:9] != 7'h34) begin
      flg[4] = r[7];
      flg[2] = (r == 8'h00);
    end
    instr_word = w; file_rdata = rd; instr_valid = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    `CHK(file_we, dst)
    if (dst) begin
      `CHK(file_wdata, r)
      `CHK(file_addr, {4'h0, w[7:0]})
    end else acc = r;
    `CHK(accum, acc)
    `CHK(flags, flg)
  endtask : run
  task t_rotate_fill;
    run(16'h4205, 8'hD7);
    run(16'h4005, 8'hD7);
    run(16'h4101, 8'h01);
    run(16'h4307, 8'h00);
    run(16'h6805, 8'h5A);
    run(16'h69FF, 8'h00);
  endtask : t_rotate_fill
  task t_subtract;
    logic [23:0] v[13];
    v = '{24'h400004, 24'h560503, 24'h5C0503, 24'h5C0502, 24'h5C0501,
      24'h5A0519, 24'h58051B, 24'h540502, 24'h080200, 24'h08FF00,
      24'h5C0580, 24'h560110, 24'h088000};
    foreach (v[i]) run(v[i][23:8], v[i][7:0]);
  endtask : t_subtract
  task t_sleep;
    instr_word = 16'h0003;
    @(posedge mclk);
    @(negedge mclk);
    `CHK({sleeping, osc_run, wdt_clear}, 3'h5)
    `CHK({sleep_entered_bit, watchdog_expired_bit}, 2'h1)
    instr_word = 16'h0802;
    @(posedge mclk);
    @(negedge mclk);
    `CHK({sleeping, wdt_clear, accum}, {2'h2, acc})
    wdt_wake = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    wdt_wake = 1'b0;
    instr_valid = 1'b0;
    `CHK({sleeping, osc_run, watchdog_expired_bit}, 3'h2)
  endtask : t_sleep
  // With the enable low nothing may move, not even a sleep request.
  task t_freeze;
    logic we_before;
    we_before = file_we;
    clk_en = 1'b0;
    instr_word = 16'h0003;
    instr_valid = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    `CHK({sleeping, osc_run, file_we}, {2'h1, we_before})
    `CHK({accum, flags}, {acc, flg})
    clk_en = 1'b1;
    run(16'h0855, 8'h00);
  endtask : t_freeze
  // A second reset in mid-run must restore every status bit.
  task t_reset;
    reset_n = 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    `CHK({osc_run, sleeping, file_we}, 3'h4)
    `CHK({watchdog_expired_bit, sleep_entered_bit}, 2'h3)
    `CHK(accum, rssso_pkg::ACCUM_RESET)
    `CHK(flags, rssso_pkg::FLAGS_RESET)
    acc = rssso_pkg::ACCUM_RESET;
    flg = rssso_pkg::FLAGS_RESET;
    reset_n = 1'b1;
    run(16'h5C05, 8'h03);
  endtask : t_reset
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK({watchdog_expired_bit, sleep_entered_bit, osc_run}, 3'h7)
    `CHK(bank_pointer, rssso_pkg::BANK_RESET)
    reset_n = 1'b1;
    t_rotate_fill();
    t_subtract();
    t_freeze();
    t_sleep();
    t_reset();
    give_verdict();
  end
endmodule : rssso_tb_top
